// ===== core/ldrm_pkg.sv
// constants, field layouts and carrier types of the local port direct-route mux
// assumes a 32-bit apb slave with 12-bit byte addresses
package ldrm_pkg;

  // clock and link timing
  localparam int unsigned PCLK_HZ       = 25_000_000;
  localparam int unsigned LINK_TCK_NS   = 320;

  // select codes that hand a port to the primary side
  localparam logic [2:0]  SEL_PORT3     = 3'h2;
  localparam logic [2:0]  SEL_PORT4     = 3'h3;
  localparam logic [2:0]  SEL_PORT5     = 3'h4;
  localparam int          NUM_PORTS     = 2;
  localparam int          NUM_DEBUG     = 3;

  // register byte addresses
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_TRACE    = 12'h008;

  // control register fields
  localparam int          CTRL_MODE_BIT = 0;
  localparam int          CTRL_SEL_LSB  = 1;
  localparam int          CTRL_SEL_MSB  = 3;
  localparam int          CTRL_GW_BIT   = 4;
  localparam logic [31:0] CTRL_MASK     = 32'h0000_001f;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;

  // status register fields
  localparam int          STAT_OVF_BIT  = 11;

  // trace buffer
  localparam int          TRACE_W       = 8;
  localparam int          TRACE_DEPTH   = 2;
  localparam logic [1:0]  TRACE_FULL    = 2'h2;
  localparam int          TRACE_VLD_BIT = 8;

  // gateway selection state
  typedef enum logic [0:0] {
    GW_WAIT_SEL = 1'b0,
    GW_ACTIVE   = 1'b1
  } ldrm_state_e;

  // the five driven lines of one local chain port
  typedef struct packed {
    logic test_clock;
    logic mode_select;
    logic data_out;
    logic test_reset;
    logic auto_write;
  } ldrm_lines_s;

  // parked value while reset is applied
  localparam logic [4:0]  LINES_RESET   = 5'h0d;

  // pins crossing into the pclk domain
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic awr;
    logic toe_n;
    logic p4_tdi;
    logic p5_tdi;
  } ldrm_pins_s;

endpackage

// ===== core/ldrm_core.sv
// direct-route mux for local chain ports 3 to 5 with apb control and trace
// assumes an apb master on pclk; all tester pins are asynchronous to pclk
// Notes on behaviour
// RQ1: routing mode high, gateway active: port5 data out is chain
// RQ2: routing mode high: port5 data in is chain
// RQ3: port3 debug enable low only for 010
// RQ4: port4 lines routed on 011 in direct mode, else tri-stated unless routing mode high
// RQ5: port4 auto write forwards primary on 011
// RQ6: port4 debug enable low only for 011
// RQ7: port5 lines routed on 100 in direct mode, else tri-stated unless routing mode high
// RQ8: port5 auto write forwards primary on 100
// RQ9: port5 debug enable low only for 100
// RQ10: after reset clocks, resets copy primary
// RQ11: after reset other outputs settle high
// RQ12: output enable low tri-states every port
// RQ13: primary reset low forces wait-for-selection
// RQ14: select code picks at most one port
`timescale 1ns/10ps
`default_nettype none

module ldrm_core (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 primary_test_clock,
  input  wire logic                 primary_mode_select,
  input  wire logic                 primary_data_in,
  input  wire logic                 primary_test_reset_n,
  input  wire logic                 primary_auto_write_in,
  input  wire logic                 test_output_enable_n,
  input  wire logic                 port4_data_in,
  input  wire logic                 port5_data_in,
  output logic                      primary_data_out,
  output logic                      primary_data_out_oe,
  output ldrm_pkg::ldrm_lines_s     port4_lines,
  output ldrm_pkg::ldrm_lines_s     port4_lines_oe,
  output ldrm_pkg::ldrm_lines_s     port5_lines,
  output ldrm_pkg::ldrm_lines_s     port5_lines_oe,
  output logic                      port3_debug_en_n,
  output logic                      port4_debug_en_n,
  output logic                      port5_debug_en_n,
  output logic      [2:0]           debug_en_oe,
  output logic                      trace_ready
);
  import ldrm_pkg::*;

  ldrm_pins_s              pins_raw;
  ldrm_pins_s              pins_meta;
  ldrm_pins_s              pins_sync;
  logic                    tck_prev;
  logic                    tck_rise;
  logic [31:0]             ctrl;
  logic                    routing_mode_ctl;
  logic [2:0]              direct_port_select;
  logic                    gateway_select;
  logic                    apb_access;
  logic                    apb_fire;
  logic                    next_pready;
  logic [31:0]             next_prdata;
  logic                    next_pslverr;
  logic                    pop_pending;
  logic                    gw_rst_n;
  ldrm_state_e             state;
  ldrm_state_e             next_state;
  ldrm_lines_s             lines_q     [NUM_PORTS];
  ldrm_lines_s             oe_q        [NUM_PORTS];
  ldrm_lines_s             next_lines  [NUM_PORTS];
  logic [NUM_PORTS-1:0]    direct;
  logic [NUM_DEBUG-1:0]    debug_q;
  logic [NUM_DEBUG-1:0]    next_debug;
  logic                    next_primary_out;
  logic                    next_primary_oe;
  logic [TRACE_W-1:0]      trace_mem   [TRACE_DEPTH];
  logic                    wr_ptr;
  logic                    rd_ptr;
  logic [1:0]              trace_count;
  logic                    trace_push;
  logic                    trace_pop;
  logic                    trace_ovf;
  logic                    ovf_clear;
  logic [TRACE_W-1:0]      trace_word;

  // every tester pin passes two flops before logic looks at it, except the raw primary reset, which also clears the state through gw_rst_n
  assign pins_raw = '{tck:    primary_test_clock,
                      tms:    primary_mode_select,
                      tdi:    primary_data_in,
                      trst_n: primary_test_reset_n,
                      awr:    primary_auto_write_in,
                      toe_n:  test_output_enable_n,
                      p4_tdi: port4_data_in,
                      p5_tdi: port5_data_in};

  // two-flop synchroniser; the meta stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_meta <= '0;
      pins_sync <= '0;
    end else begin
      pins_meta <= pins_raw;
      pins_sync <= pins_meta;
    end
  end

  // link clock edge detection on the synchronised copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tck_prev <= 1'b0;
    end else begin
      tck_prev <= pins_sync.tck;
    end
  end

  assign tck_rise = pins_sync.tck & ~tck_prev;

  // control fields
  assign routing_mode_ctl   = ctrl[CTRL_MODE_BIT];
  assign direct_port_select = ctrl[CTRL_SEL_MSB:CTRL_SEL_LSB];
  assign gateway_select     = ctrl[CTRL_GW_BIT];

  // apb: one wait state so that read data comes from a flop
  assign apb_access  = psel & penable;
  assign apb_fire    = apb_access & pready;
  assign next_pready = apb_access & ~pready;

  // read mux and decode, loaded in the first access cycle
  always_comb begin
    next_prdata  = 32'h0;
    next_pslverr = 1'b0;
    case (paddr)
      ADDR_CTRL: begin
        next_prdata = ctrl;
      end
      ADDR_STATUS: begin
        next_prdata = {20'h0, trace_ovf, trace_count, pins_sync,
                       state};
      end
      ADDR_TRACE: begin
        if (trace_count != 2'h0) begin
          next_prdata = {23'h0, 1'b1, trace_mem[rd_ptr]};
        end
      end
      default: begin
        next_pslverr = 1'b1; // unmapped: error, reads zero
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready      <= 1'b0;
      prdata      <= 32'h0;
      pslverr     <= 1'b0;
      pop_pending <= 1'b0;
    end else begin
      pready <= next_pready;
      if (next_pready) begin
        prdata      <= next_prdata;
        pslverr     <= next_pslverr;
        // pop only the word that was actually shown to the master
        pop_pending <= ~pwrite && (paddr == ADDR_TRACE) &&
                       (trace_count != 2'h0);
      end
    end
  end

  // control register; a primary reset drops the gateway selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else begin
      if (apb_fire && pwrite && (paddr == ADDR_CTRL)) begin
        ctrl <= pwdata & CTRL_MASK;
      end
      if (!pins_sync.trst_n) begin
        ctrl[CTRL_GW_BIT] <= 1'b0; // RQ13
      end
    end
  end

  // the raw primary reset pin clears the state without a clock
  assign gw_rst_n = presetn & primary_test_reset_n; // RQ13

  always_comb begin
    next_state = state;
    case (state)
      GW_WAIT_SEL: begin
        if (gateway_select) begin
          next_state = GW_ACTIVE;
        end
      end
      GW_ACTIVE: begin
        if (!gateway_select) begin
          next_state = GW_WAIT_SEL;
        end
      end
      default: begin
        next_state = GW_WAIT_SEL;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge gw_rst_n) begin
    if (!gw_rst_n) begin
      state <= GW_WAIT_SEL; // RQ13
    end else begin
      state <= next_state;
    end
  end

  // per-port routing; port 4 heads the chain, port 5 follows it
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    localparam logic [2:0] CODE = (g == 0) ? SEL_PORT4 : SEL_PORT5;
    logic chain_data;

    // a select code equals one port code at most
    assign direct[g] = ~routing_mode_ctl &
                       (direct_port_select == CODE); // RQ4 RQ7 RQ14
    // normal chain: port 5 shifts what port 4 returned
    assign chain_data = (g == 0) ? pins_sync.tdi
                                 : pins_sync.p4_tdi; // RQ1 RQ2

    always_comb begin
      // parked: clock and reset copied, the rest high
      next_lines[g] = '{test_clock:  pins_sync.tck,
                        mode_select: 1'b1,
                        data_out:    1'b1,
                        test_reset:  pins_sync.trst_n,
                        auto_write:  1'b1}; // RQ10 RQ11
      if (direct[g]) begin
        next_lines[g] = '{test_clock:  pins_sync.tck,
                          mode_select: pins_sync.tms,
                          data_out:    pins_sync.tdi,
                          test_reset:  pins_sync.trst_n,
                          auto_write:  pins_sync.awr}; // RQ4 RQ5 RQ7 RQ8
      end else if (routing_mode_ctl && (state == GW_ACTIVE)) begin
        next_lines[g].mode_select = pins_sync.tms; // RQ11
        next_lines[g].data_out    = chain_data;    // RQ1
      end
    end

    // outputs registered; tri-state unless routed or in normal mode
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lines_q[g] <= ldrm_lines_s'(LINES_RESET);
        oe_q[g]    <= '0;
      end else begin
        lines_q[g] <= next_lines[g];
        if (pins_sync.toe_n && (routing_mode_ctl || direct[g])) begin
          oe_q[g] <= '1; // RQ4 RQ7
        end else begin
          oe_q[g] <= '0; // RQ12
        end
      end
    end
  end

  assign port4_lines    = lines_q[0];
  assign port4_lines_oe = oe_q[0];
  assign port5_lines    = lines_q[1];
  assign port5_lines_oe = oe_q[1];

  // debug enables: low only for the matching code in direct mode
  for (genvar d = 0; d < NUM_DEBUG; d++) begin : g_debug
    localparam logic [2:0] DCODE = (d == 0) ? SEL_PORT3 :
                                   (d == 1) ? SEL_PORT4 : SEL_PORT5;
    assign next_debug[d] = ~(~routing_mode_ctl &
                             (direct_port_select == DCODE)); // RQ3 RQ6 RQ9
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_q     <= '1;
      debug_en_oe <= '0;
    end else begin
      debug_q     <= next_debug;
      debug_en_oe <= {NUM_DEBUG{pins_sync.toe_n}}; // RQ12
    end
  end

  assign port3_debug_en_n = debug_q[0];
  assign port4_debug_en_n = debug_q[1];
  assign port5_debug_en_n = debug_q[2];

  // primary data out: routed port, or chain tail; off when not selected
  always_comb begin
    next_primary_out = 1'b1;
    if (direct[0]) begin
      next_primary_out = pins_sync.p4_tdi;
    end else if (direct[1] || routing_mode_ctl) begin
      next_primary_out = pins_sync.p5_tdi; // RQ2
    end
  end

  // port 3 is routed elsewhere, so this mux keeps its data pin off then
  assign next_primary_oe = (state == GW_ACTIVE) &&
                           (routing_mode_ctl || (direct != '0));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_data_out    <= 1'b1;
      primary_data_out_oe <= 1'b0;
    end else begin
      primary_data_out    <= next_primary_out;
      primary_data_out_oe <= next_primary_oe;
    end
  end

  // trace: one word per link clock rise while the gateway is selected
  // limitation: the tester cannot be stalled, so a full buffer drops
  // the word and flags it instead
  assign trace_word  = {direct_port_select, routing_mode_ctl, state,
                        pins_sync.tms, pins_sync.tdi, next_primary_out};
  assign trace_ready = (trace_count != TRACE_FULL);
  assign trace_push  = tck_rise && (state == GW_ACTIVE) && trace_ready;
  assign trace_pop   = apb_fire && pop_pending;
  assign ovf_clear   = apb_fire && pwrite && (paddr == ADDR_STATUS) &&
                       pwdata[STAT_OVF_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr      <= 1'b0;
      rd_ptr      <= 1'b0;
      trace_count <= 2'h0;
    end else begin
      if (trace_push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (trace_pop) begin
        rd_ptr <= ~rd_ptr;
      end
      case ({trace_push, trace_pop})
        2'b10:   trace_count <= trace_count + 2'h1;
        2'b01:   trace_count <= trace_count - 2'h1;
        default: trace_count <= trace_count;
      endcase
    end
  end

  // storage flops, written at the head index
  always_ff @(posedge pclk) begin
    if (trace_push) begin
      trace_mem[wr_ptr] <= trace_word;
    end
  end

  // sticky overflow; a new drop beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trace_ovf <= 1'b0;
    end else if (tck_rise && (state == GW_ACTIVE) && !trace_ready) begin
      trace_ovf <= 1'b1;
    end else if (ovf_clear) begin
      trace_ovf <= 1'b0;
    end
  end

endmodule // ldrm_core

`default_nettype wire

// ===== testbench/ldrm_checker.sv
// port assertions for the local chain port direct-route mux
// assumes binding onto ldrm_core; pins reach the outputs in 3 edges
`timescale 1ns/10ps
`default_nettype none

module ldrm_checker
  import ldrm_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  primary_test_clock,
  input wire logic                  primary_test_reset_n,
  input wire logic                  primary_auto_write_in,
  input wire logic                  test_output_enable_n,
  input wire logic                  port4_data_in,
  input wire logic                  port5_data_in,
  input wire logic                  primary_data_out,
  input wire logic                  primary_data_out_oe,
  input wire ldrm_pkg::ldrm_lines_s port4_lines,
  input wire ldrm_pkg::ldrm_lines_s port4_lines_oe,
  input wire ldrm_pkg::ldrm_lines_s port5_lines,
  input wire ldrm_pkg::ldrm_lines_s port5_lines_oe,
  input wire logic                  port3_debug_en_n,
  input wire logic                  port4_debug_en_n,
  input wire logic                  port5_debug_en_n,
  input wire logic [2:0]            debug_en_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // five samples cover the two sync flops and the output flop
  sequence s_toe_on;
    test_output_enable_n[*5];
  endsequence
  sequence s_awr_held;
    $stable(primary_auto_write_in)[*5];
  endsequence

  // reset may first land at a clock edge, so look one edge into it
  a_reset_levels: assert property (disable iff (1'b0)
    !presetn ##1 !presetn |->
    {port4_lines.mode_select, port5_lines.data_out, port4_lines.auto_write,
     port3_debug_en_n, port4_debug_en_n, port5_debug_en_n} == 6'h3f)
    else $error("outputs not parked high during reset");
  a_buffered_copy: assert property ((port4_lines_oe == 5'h1f &&
    $stable(primary_test_clock) && $stable(primary_test_reset_n))[*5] |->
    port4_lines.test_clock == primary_test_clock &&
    port4_lines.test_reset == primary_test_reset_n)
    else $error("port clock or reset not a copy of the primary");
  a_toe_tristate: assert property ((!test_output_enable_n)[*5] |->
    {port4_lines_oe, port5_lines_oe, debug_en_oe} == 13'h0)
    else $error("port driven while output enable is off");
  a_port4_route: assert property (s_toe_on and (!port4_debug_en_n)[*5]
    |-> port4_lines_oe == 5'h1f && port5_lines_oe == 5'h0)
    else $error("port 4 routing enables wrong");
  a_port5_route: assert property (s_toe_on and (!port5_debug_en_n)[*5]
    |-> port5_lines_oe == 5'h1f && port4_lines_oe == 5'h0)
    else $error("port 5 routing enables wrong");
  a_auto_write: assert property (s_awr_held |-> (port4_debug_en_n ||
    port4_lines.auto_write == primary_auto_write_in) && (port5_debug_en_n ||
    port5_lines.auto_write == primary_auto_write_in))
    else $error("auto write not forwarded");
  a_port3_only: assert property (!port3_debug_en_n |-> port4_debug_en_n &&
    port5_debug_en_n && port4_lines_oe == 5'h0 && port5_lines_oe == 5'h0)
    else $error("second port active beside port 3");
  a_normal_chain: assert property ((primary_data_out_oe &&
    port4_lines_oe == 5'h1f && port5_lines_oe == 5'h1f &&
    $stable(port4_data_in) && $stable(port5_data_in))[*5] |->
    port5_lines.data_out == port4_data_in && primary_data_out == port5_data_in)
    else $error("normal chain data path wrong");
endmodule // ldrm_checker

bind ldrm_core ldrm_checker ldrm_checker_i (.*);

`default_nettype wire

// ===== testbench/ldrm_partner.sv
// tester and local scan chain stand-ins for the direct-route mux
// assumes the bench raises frame around each burst of link clocks
`timescale 1ns/10ps
`default_nettype none

module ldrm_partner
  import ldrm_pkg::*;
(
  input  wire logic                  frame,
  input  wire ldrm_pkg::ldrm_lines_s p4_lines,
  input  wire ldrm_pkg::ldrm_lines_s p4_oe,
  input  wire ldrm_pkg::ldrm_lines_s p5_lines,
  input  wire ldrm_pkg::ldrm_lines_s p5_oe,
  output logic                       tck,
  output logic                       tms,
  output logic                       tdi,
  output logic                       p4_tdi,
  output logic                       p5_tdi
);
  // 320 ns link clock, offset from pclk; stands low outside frames
  initial begin
    tck = 1'b0;
    #37;
    forever begin
      #160;
      if (frame || tck) tck = ~tck;
    end
  end

  // tester moves mode and data on the falling link clock
  initial {tms, tdi} = 2'h3;
  always @(negedge tck) {tms, tdi} <= 2'($urandom);

  // each chain is one stage; it shifts only on a driven clock
  initial {p4_tdi, p5_tdi} = 2'h0;
  always @(posedge p4_lines.test_clock) if (p4_oe.test_clock)
    p4_tdi <= p4_lines.data_out;
  always @(posedge p5_lines.test_clock) if (p5_oe.test_clock)
    p5_tdi <= p5_lines.data_out;
endmodule // ldrm_partner

`default_nettype wire

// ===== testbench/lsp_direct_route_mux_tb.sv
// self-checking bench for the local chain port direct-route mux
// assumes ldrm_pkg, ldrm_core, ldrm_partner and the bound checker
`timescale 1ns/10ps
`default_nettype none

module lsp_direct_route_mux_tb;
  import ldrm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        primary_test_clock, primary_mode_select, primary_data_in;
  logic        primary_test_reset_n, primary_auto_write_in, frame;
  logic        test_output_enable_n, port4_data_in, port5_data_in;
  logic        primary_data_out, primary_data_out_oe, trace_ready;
  logic        port3_debug_en_n, port4_debug_en_n, port5_debug_en_n;
  logic [2:0]  debug_en_oe, e;
  logic [3:0]  c;
  ldrm_lines_s port4_lines, port4_lines_oe, port5_lines, port5_lines_oe;
  int          n_errors, n_compared, i, k;

  ldrm_core ldrm_core_i (.*);
  ldrm_partner ldrm_partner_i (.frame(frame), .p4_lines(port4_lines),
    .p4_oe(port4_lines_oe), .p5_lines(port5_lines), .p5_oe(port5_lines_oe),
    .tck(primary_test_clock), .tms(primary_mode_select),
    .tdi(primary_data_in), .p4_tdi(port4_data_in), .p5_tdi(port5_data_in));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic give_verdict;
    $display("errors %0d compares %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one compare; a mismatch is counted and shown at once
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      n_errors++;
      give_verdict();
    end
  endtask

  // active-low enables {p5,p4,p3}: low only in direct mode on own code
  function automatic logic [2:0] exp_dbg(input logic [3:0] w);
    for (int p = 0; p < 3; p++)
      exp_dbg[p] = !(w[0] == 1'b0 && w[3:1] == 3'(p + 2));
  endfunction

  initial begin
    void'($urandom(62020));
    {presetn, psel, penable, pwrite, frame, paddr, pwdata} = '0;
    {primary_test_reset_n, primary_auto_write_in} = 2'h3;
    test_output_enable_n = 1'b1;
    n_errors = 0;
    n_compared = 0;
    cyc(16);
    check({port4_lines.mode_select, port4_lines.data_out,
           port5_lines.auto_write, port4_debug_en_n}, 4'hf);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, 12'h00c, 32'h1f);
    check(err, 1'b1);
    apb(1'b0, 12'h00c, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    check({port5_lines.mode_select, port5_lines.data_out}, 2'h3);
    check({port4_lines.test_clock, port4_lines.test_reset}, 2'h1);
    // every mode and select code, then random words and auto-write levels
    for (i = 0; i < 28; i++) begin
      c = (i < 16) ? 4'(i) : 4'($urandom);
      primary_auto_write_in <= 1'($urandom);
      apb(1'b1, ADDR_CTRL, {28'h0, c});
      cyc(5);
      e = exp_dbg(c);
      check({port5_debug_en_n, port4_debug_en_n, port3_debug_en_n}, e);
      check(port4_lines_oe, (c[0] || !e[1]) ? 5'h1f : 5'h0);
      check(port5_lines_oe, (c[0] || !e[2]) ? 5'h1f : 5'h0);
      if (!e[1]) check(port4_lines.auto_write, primary_auto_write_in);
      if (!e[2]) check(port5_lines.auto_write, primary_auto_write_in);
    end
    test_output_enable_n <= 1'b0;
    cyc(5);
    check({port4_lines_oe, port5_lines_oe, debug_en_oe}, 13'h0);
    test_output_enable_n <= 1'b1;
    // normal chain with gateway selected; trace fills while nobody reads
    apb(1'b1, ADDR_CTRL, 32'h11);
    frame <= 1'b1;
    cyc(300);
    frame <= 1'b0;
    cyc(20);
    check(primary_data_out_oe, 1'b1);
    check(port5_lines.data_out, port4_data_in);
    check(primary_data_out, port5_data_in);
    check(port4_lines.mode_select, primary_mode_select);
    check(port4_lines.data_out, primary_data_in);
    check(trace_ready, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({rd[11:9], rd[0]}, 4'hd);
    for (i = 0; i < 3; i++) begin
      apb(1'b0, ADDR_TRACE, 32'h0);
      check(rd[8], i < 2);
    end
    check(trace_ready, 1'b1);
    // sticky drop flag clears on a write of one, link clock is idle
    apb(1'b1, ADDR_STATUS, 32'h1 << STAT_OVF_BIT);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[STAT_OVF_BIT], 1'b0);
    // port 4 handed straight to the tester while the link runs
    apb(1'b1, ADDR_CTRL, 32'h16);
    frame <= 1'b1;
    cyc(40);
    frame <= 1'b0;
    cyc(20);
    check(port4_lines.mode_select, primary_mode_select);
    check(port4_lines.data_out, primary_data_in);
    check(primary_data_out, port4_data_in);
    primary_test_reset_n <= 1'b0;
    cyc(5);
    check({primary_data_out_oe, port4_lines.test_reset}, 2'h0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd[4], 1'b0);
    primary_test_reset_n <= 1'b1;
    cyc(5);
    give_verdict();
  end
endmodule // lsp_direct_route_mux_tb

`default_nettype wire
